// >>> rtl/sfd_datapath.sv
// Fabric-side transceiver datapath: coding, 4:1 conversion, word and channel alignment.
// How it works
// - coded mode moves 32 data plus 4 flags.
// - fabric word clock stays within 25.0-92.5 MHz.
// - symbol interface runs at bit rate over ten.
// - four symbols per fabric word, quarter rate.
// - K28.1, K28.5, K28.7 count as commas.
// - align on comma or /A/, deliver the character.
// - bypassed channels give own clock and comma flag.
// - decoder off delivers four raw symbols, 40 bits.
// - pairs and four-channel groups are supported.
// - one group may span all eight channels.
// - four-channel part: pairs or all four.
// - powered-down member never stalls its group.
// - each channel may run ungrouped.
// - eight streams each way with status, control.
// - per-channel 8b/10b encode and decode with errors.
// - group alignment machine and per-channel sync machine.
// - per-channel controls plus global controls.
// - per-lane inputs force negative transmit disparity.
// - symbol bit a goes first, j last.

// Three-stage synchroniser; each bit moves once stages two and three agree.
module sfd_sync3 #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_ff; // First stage, read only by the second.
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] q_ff; // Filtered output.

	// Shift the input through and take a bit once two samples agree.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			q_ff <= '0;
		end else begin
			s1_ff <= d_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			q_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (q_ff & (s2_ff ^ s3_ff));
		end
	end
	assign q_o = q_ff;
endmodule

// Top level: link side on lclk_i, fabric side on clk_i.
module sfd_datapath import sfd_pkg::*; #(
	parameter int NCH = 8,
	parameter int LANE_MBPS = SFD_LANE_MBPS
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic lclk_i,
	input wire logic [NCH-1:0][9:0] rx_sym_i,
	output logic [NCH-1:0][9:0] tx_sym_o,
	input wire logic [NCH-1:0] chan_pd_i,
	input wire logic [NCH-1:0] dec_en_i,
	input wire logic align_bypass_i,
	input wire sfd_grp_t grp_mode_i,
	output logic [NCH-1:0][39:0] rx_data_o,
	output logic [NCH-1:0] rx_valid_o,
	output logic [NCH-1:0] rx_comma_o,
	output logic [NCH-1:0] rx_wclk_o,
	output logic [NCH-1:0] rx_sync_o,
	output logic [NCH/4-1:0] link_aligned_o,
	input wire logic [NCH-1:0][31:0] tx_data_i,
	input wire logic [NCH-1:0][3:0] tx_k_i,
	input wire logic [NCH-1:0][3:0] tx_fneg_i,
	input wire logic [NCH-1:0] tx_valid_i,
	output logic [NCH-1:0] tx_ready_o
);
	// Fabric word rate in kHz that follows from the lane rate.
	localparam int FAB_KHZ = LANE_MBPS * 1000 / (SFD_WORD_DIV * SFD_FAB_DIV);
	// Refuse channel counts and lane rates the datapath cannot serve.
	if (NCH != 4 && NCH != 8) begin : g_bad_nch
		$error("NCH must be 4 or 8");
	end
	if (FAB_KHZ < SFD_FAB_MIN_KHZ || FAB_KHZ > SFD_FAB_MAX_KHZ) begin : g_bad_rate
		$error("LANE_MBPS gives a fabric clock out of range");
	end
	// Link-domain copies of power-down and decoder-enable controls.
	logic [2*NCH-1:0] ctl_l;
	// Fabric-side state shared by the grouping logic.
	logic [NCH-1:0] pend_ff; // A received word waits for delivery.
	logic [NCH-1:0] sync_f; // Channel sync as seen in the fabric domain.
	logic [NCH-1:0] grp_on; // Channel takes part in grouped delivery.
	logic [NCH-1:0] grp_ok; // Every live group mate also has a word.
	logic [NCH-1:0] deliver; // Word goes out this cycle.
	logic [NCH-1:0] a_hit; // Delivered word starts with /A/.
	// Controls are fabric-side levels; they cross into the link domain.
	sfd_sync3 #(.W(2*NCH)) u_ctl_sync (
		.clk_i(lclk_i),
		.reset_n_i(reset_n_i),
		.d_i({dec_en_i, chan_pd_i}),
		.q_o(ctl_l)
	);
	// Group index of a channel under a grouping mode.
	function automatic int sfd_gid(input int c, input sfd_grp_t g);
		case (g)
			SFD_GRP_PAIR: return c / 2;
			SFD_GRP_QUAD: return c / 4;
			SFD_GRP_ALL: return 0;
			default: return c;
		endcase
	endfunction
	// Finds the lowest bit offset of a comma in a two-symbol window.
	function automatic logic [4:0] sfd_find(input logic [19:0] w);
		logic [4:0] r;
		r = 5'h00;
		for (int o = 9; o >= 0; o--) begin
			if (w[19-o -: 7] == SFD_COMMA || w[19-o -: 7] == ~SFD_COMMA) r = {1'b1, 4'(o)};
		end
		return r;
	endfunction
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		// Link-side receive state.
		logic [9:0] prev_ff; // Previous raw symbol.
		logic [3:0] off_ff; // Locked bit offset of the word boundary.
		logic [9:0] sym_ff; // Boundary-aligned symbol.
		logic [19:0] win; // Older symbol on top, as bits arrived.
		logic [4:0] hit;
		logic [9:0] dec;
		logic is_algn; // Comma or /A/ seen.
		logic is_comma;
		sfd_sy_t sy_ff;
		logic [1:0] acq_ff; // Commas counted while acquiring.
		logic [2:0] errc_ff; // Consecutive code errors while in sync.
		logic [1:0] rlane_ff; // Next receive lane.
		logic [1:0] lane_w;
		logic [39:0] quad_ff; // Word under assembly.
		logic [39:0] nxt_quad;
		logic [39:0] hold_ff; // Finished word, stable for the fabric.
		logic cm_ff; // Comma seen in the word under assembly.
		logic hcm_ff;
		logic rtog_ff; // Flips once per finished word.
		logic pd_l;
		logic den_l;
		logic run_l;
		// Fabric-side receive state.
		logic rtog_f;
		logic seen_ff;
		logic [39:0] rdat_ff;
		logic rcm_ff;
		logic [39:0] out_ff;
		logic ocm_ff;
		logic val_ff;
		logic newword;
		// Transmit state on both sides.
		logic req_ff; // Fabric request toggle.
		logic ack_f;
		logic [39:0] txq_ff; // Fabric word {force, flags, data}.
		logic req_l;
		logic ackt_ff; // Link acknowledge toggle.
		logic [1:0] tlane_ff;
		logic [39:0] tq_ff; // Quad being sent.
		logic rd_ff; // Running disparity, low is negative.
		logic [9:0] tsym_ff;
		logic [10:0] enc;
		assign pd_l = ctl_l[c];
		assign den_l = ctl_l[NCH+c];
		assign win = {prev_ff, rx_sym_i[c]};
		assign hit = sfd_find(win);
		assign dec = sfd_dec(sym_ff);
		assign is_comma = !dec[9] && dec[8] && (dec[7:0] == SFD_K28_1 || dec[7:0] == SFD_K28_5
			|| dec[7:0] == SFD_K28_7);
		assign is_algn = is_comma || (!dec[9] && dec[8] && dec[7:0] == SFD_K28_3);
		assign run_l = (sy_ff == SFD_SY_SYNC) || !den_l;
		assign lane_w = is_algn ? 2'h0 : rlane_ff;
		// Place the symbol, or its decoded byte and flags, into its lane.
		always_comb begin
			nxt_quad = quad_ff;
			if (den_l) begin
				nxt_quad[lane_w*8 +: 8] = dec[7:0];
				nxt_quad[32+lane_w] = dec[8];
				nxt_quad[36+lane_w] = dec[9];
			end else begin
				nxt_quad[lane_w*10 +: 10] = sym_ff;
			end
		end
		// Word boundary, sync machine and lane assembly on the link clock.
		always_ff @(posedge lclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				prev_ff <= 10'h000;
				off_ff <= 4'h0;
				sym_ff <= 10'h000;
				sy_ff <= SFD_SY_LOSS;
				acq_ff <= 2'h0;
				errc_ff <= 3'h0;
				rlane_ff <= 2'h0;
				quad_ff <= 40'h0;
				hold_ff <= 40'h0;
				cm_ff <= 1'b0;
				hcm_ff <= 1'b0;
				rtog_ff <= 1'b0;
			end else if (pd_l) begin
				// A powered-down channel stops and drops sync; its mates carry on.
				sy_ff <= SFD_SY_LOSS;
				rlane_ff <= 2'h0;
				cm_ff <= 1'b0;
			end else begin
				prev_ff <= rx_sym_i[c];
				sym_ff <= win[19-off_ff -: 10];
				if (sy_ff == SFD_SY_LOSS && hit[4]) off_ff <= hit[3:0];
				case (sy_ff)
					SFD_SY_LOSS: begin
						acq_ff <= 2'h1;
						if (is_comma) sy_ff <= SFD_SY_ACQ;
					end
					SFD_SY_ACQ: begin
						if (dec[9]) sy_ff <= SFD_SY_LOSS;
						else if (is_comma && acq_ff == SFD_ACQ_N - 2'h1) sy_ff <= SFD_SY_SYNC;
						else if (is_comma) acq_ff <= acq_ff + 2'h1;
						errc_ff <= 3'h0;
					end
					SFD_SY_SYNC: begin
						if (dec[9] && errc_ff == SFD_LOSS_N - 3'h1) sy_ff <= SFD_SY_LOSS;
						errc_ff <= dec[9] ? errc_ff + 3'h1 : 3'h0;
					end
					default: sy_ff <= SFD_SY_LOSS;
				endcase
				if (run_l) begin
					quad_ff <= nxt_quad;
					rlane_ff <= lane_w + 2'h1;
					cm_ff <= (lane_w == 2'h3) ? 1'b0 : ((cm_ff && lane_w != 2'h0) | is_comma); // Lane 0 restarts it.
					if (lane_w == 2'h3) begin
						hold_ff <= nxt_quad;
						hcm_ff <= cm_ff | is_comma;
						rtog_ff <= ~rtog_ff;
					end
				end
			end
		end
		// Word toggle and sync level cross into the fabric domain.
		sfd_sync3 #(.W(2)) u_rx_sync (
			.clk_i(clk_i),
			.reset_n_i(reset_n_i),
			.d_i({sy_ff == SFD_SY_SYNC, rtog_ff}),
			.q_o({sync_f[c], rtog_f})
		);
		assign newword = rtog_f != seen_ff;
		// Grouping needs decoded data and no bypass; raw mode runs alone.
		assign grp_on[c] = !align_bypass_i && dec_en_i[c] && grp_mode_i != SFD_GRP_NONE && !chan_pd_i[c];
		assign a_hit[c] = deliver[c] && rdat_ff[32] && rdat_ff[7:0] == SFD_K28_3;
		// Capture finished words and send them out when the group is ready.
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				seen_ff <= 1'b0;
				rdat_ff <= 40'h0;
				rcm_ff <= 1'b0;
				pend_ff[c] <= 1'b0;
				out_ff <= 40'h0;
				ocm_ff <= 1'b0;
				val_ff <= 1'b0;
			end else begin
				seen_ff <= rtog_f;
				if (newword) begin
					rdat_ff <= hold_ff;
					rcm_ff <= hcm_ff;
				end
				// A new word wins over the delivery clear.
				pend_ff[c] <= newword | (pend_ff[c] & ~deliver[c]);
				val_ff <= deliver[c];
				if (deliver[c]) begin
					out_ff <= rdat_ff;
					ocm_ff <= rcm_ff;
				end
			end
		end
		assign rx_data_o[c] = out_ff;
		assign rx_comma_o[c] = ocm_ff;
		assign rx_valid_o[c] = val_ff;
		assign rx_wclk_o[c] = seen_ff;
		assign rx_sync_o[c] = sync_f[c];

		// Transmit request from the fabric; the word stands until acknowledged.
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				req_ff <= 1'b0;
				txq_ff <= 40'h0;
			end else if (tx_valid_i[c] && req_ff == ack_f) begin
				req_ff <= ~req_ff;
				txq_ff <= {tx_fneg_i[c], tx_k_i[c], tx_data_i[c]};
			end
		end
		assign tx_ready_o[c] = req_ff == ack_f;

		sfd_sync3 #(.W(1)) u_req_sync (
			.clk_i(lclk_i),
			.reset_n_i(reset_n_i),
			.d_i(req_ff),
			.q_o(req_l)
		);
		sfd_sync3 #(.W(1)) u_ack_sync (
			.clk_i(clk_i),
			.reset_n_i(reset_n_i),
			.d_i(ackt_ff),
			.q_o(ack_f)
		);

		// Encode one lane per link clock, lowest lane first; a forced lane starts negative.
		assign enc = sfd_enc(tq_ff[tlane_ff*8 +: 8], tq_ff[32+tlane_ff], tq_ff[36+tlane_ff] ? 1'b0 : rd_ff);

		// Serialize quads to symbols and take the next quad at the lane wrap.
		always_ff @(posedge lclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				ackt_ff <= 1'b0;
				tlane_ff <= 2'h0;
				tq_ff <= SFD_TX_IDLE;
				rd_ff <= 1'b0;
				tsym_ff <= 10'h000;
			end else begin
				tsym_ff <= enc[10:1];
				rd_ff <= enc[0];
				tlane_ff <= tlane_ff + 2'h1;
				if (tlane_ff == 2'h3) begin
					tq_ff <= (req_l != ackt_ff) ? txq_ff : SFD_TX_IDLE;
					ackt_ff <= req_l;
				end
			end
		end
		assign tx_sym_o[c] = tsym_ff;
	end

	// A grouped channel goes out only when every live mate holds a word.
	always_comb begin
		grp_ok = '1;
		for (int c = 0; c < NCH; c++) begin
			for (int m = 0; m < NCH; m++) begin
				if (m != c && grp_on[c] && grp_on[m] && !pend_ff[m]
					&& sfd_gid(c, grp_mode_i) == sfd_gid(m, grp_mode_i)) grp_ok[c] = 1'b0;
			end
		end
	end
	assign deliver = pend_ff & grp_ok;

	// One alignment machine per block of four channels.
	for (genvar b = 0; b < NCH / 4; b++) begin : g_blk
		sfd_xa_t xa_ff;
		logic all_sync; // Every live channel of the block is in sync.
		logic all_a; // Every live channel delivered /A/ together.
		assign all_sync = &(sync_f[b*4 +: 4] | chan_pd_i[b*4 +: 4]);
		assign all_a = &(a_hit[b*4 +: 4] | chan_pd_i[b*4 +: 4]) && !(&chan_pd_i[b*4 +: 4]);

		// Aligned once lanes agree on /A/; lost when any live lane drops sync.
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				xa_ff <= SFD_XA_WAIT;
			end else begin
				case (xa_ff)
					SFD_XA_WAIT: if (all_sync && all_a) xa_ff <= SFD_XA_ALIGNED;
					SFD_XA_ALIGNED: if (!all_sync) xa_ff <= SFD_XA_WAIT;
					default: xa_ff <= SFD_XA_WAIT;
				endcase
			end
		end
		assign link_aligned_o[b] = xa_ff == SFD_XA_ALIGNED;
	end
endmodule

// >>> rtl/sfd_pkg.sv
// Shared constants, types and 8b/10b coding functions of the fabric datapath.
package sfd_pkg;

	// Byte lanes per fabric word and width of one coded symbol.
	localparam int SFD_LANES = 4;
	localparam int SFD_SYM_W = 10;
	// Serial bit rate over intermediate word rate, and intermediate over fabric rate.
	localparam int SFD_WORD_DIV = 10;
	localparam int SFD_FAB_DIV = 4;
	// Allowed fabric word clock range in kHz.
	localparam int SFD_FAB_MIN_KHZ = 25000;
	localparam int SFD_FAB_MAX_KHZ = 92500;
	// Default serial lane rate in Mbps.
	localparam int SFD_LANE_MBPS = 3700;
	// Comma bit pattern in the first seven symbol bits, and the K28 six-bit block.
	localparam logic [6:0] SFD_COMMA = 7'h1f;
	localparam logic [5:0] SFD_K28_6B = 6'h0f;
	// Alternate four-bit block for x.7 characters.
	localparam logic [3:0] SFD_A7 = 4'h7;
	// Special character byte values.
	localparam logic [7:0] SFD_K28_1 = 8'h3c;
	localparam logic [7:0] SFD_K28_3 = 8'h7c;
	localparam logic [7:0] SFD_K28_5 = 8'hbc;
	localparam logic [7:0] SFD_K28_7 = 8'hfc;
	// Commas needed to gain sync, and consecutive code errors that lose it.
	localparam logic [1:0] SFD_ACQ_N = 2'h3;
	localparam logic [2:0] SFD_LOSS_N = 3'h4;
	// Idle transmit quad: four K28.5 with no forced disparity.
	localparam logic [39:0] SFD_TX_IDLE = {4'h0, 4'hf, {4{SFD_K28_5}}};
	// Negative-disparity five-to-six and three-to-four code tables.
	localparam logic [5:0] SFD_T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b,
		6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
	localparam logic [3:0] SFD_T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

	// Channel grouping modes of the alignment logic.
	typedef enum logic [1:0] {SFD_GRP_NONE, SFD_GRP_PAIR, SFD_GRP_QUAD, SFD_GRP_ALL} sfd_grp_t;
	// Receive synchronisation states.
	typedef enum logic [1:0] {SFD_SY_LOSS, SFD_SY_ACQ, SFD_SY_SYNC} sfd_sy_t;
	// Group alignment states.
	typedef enum logic {SFD_XA_WAIT, SFD_XA_ALIGNED} sfd_xa_t;

	// Encodes one byte; returns {abcdei fghj, new running disparity}, bit a at the top.
	function automatic logic [10:0] sfd_enc(input logic [7:0] d, input logic k, input logic rd);
		logic [5:0] s6;
		logic [3:0] s4;
		logic r;
		logic alt;
		s6 = (k && d[4:0] == 5'h1c) ? SFD_K28_6B : SFD_T6[d[4:0]];
		if (rd && ($countones(s6) != 3 || s6 == 6'h38)) s6 = ~s6;
		r = rd ^ ($countones(s6) != 3);
		alt = (d[7:5] == 3'h7) && (k || (!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14))
			|| (r && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e)));
		s4 = alt ? SFD_A7 : SFD_T4[d[7:5]];
		// A K28 character sent from positive disparity is the full complement of its negative form.
		if (k && d[4:0] == 5'h1c && rd && $countones(s4) == 2 && s4 != 4'hc) s4 = ~s4;
		if (r && ($countones(s4) != 2 || s4 == 4'hc)) s4 = ~s4;
		return {s6, s4, r ^ ($countones(s4) != 2)};
	endfunction

	// Decodes one symbol; returns {code error, special flag, byte}.
	function automatic logic [9:0] sfd_dec(input logic [9:0] s);
		logic [5:0] s6;
		logic [3:0] s4;
		logic [4:0] x;
		logic [2:0] y;
		logic f6;
		logic f4;
		logic k28;
		logic alt;
		s6 = s[9:4];
		k28 = (s6 == SFD_K28_6B) || (s6 == ~SFD_K28_6B);
		s4 = (s6 == ~SFD_K28_6B) ? ~s[3:0] : s[3:0];
		x = 5'h1c;
		y = 3'h0;
		f6 = k28;
		f4 = 1'b0;
		alt = (s4 == SFD_A7) || (s4 == ~SFD_A7);
		for (int i = 0; i < 32; i++) begin
			if (SFD_T6[i] == s6 || (~SFD_T6[i] == s6 && (i == 7 || $countones(SFD_T6[i]) != 3))) begin
				x = 5'(i);
				f6 = 1'b1;
			end
		end
		for (int i = 0; i < 8; i++) begin
			if (SFD_T4[i] == s4 || (~SFD_T4[i] == s4 && (i == 3 || $countones(SFD_T4[i]) != 2))) begin
				y = 3'(i);
				f4 = 1'b1;
			end
		end
		if (alt) begin
			y = 3'h7;
			f4 = 1'b1;
		end
		return {!(f6 && f4), k28 || (alt && (x == 5'h17 || x == 5'h1b || x == 5'h1d || x == 5'h1e)), y, x};
	endfunction

endpackage

// >>> test/sfd_datapath_assertions.sv
// Concurrent port checks of the fabric datapath.
module sfd_datapath_checker import sfd_pkg::*; #(
	parameter int NCH = 8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic lclk_i,
	input wire logic [NCH-1:0] chan_pd_i,
	input wire logic [NCH-1:0] dec_en_i,
	input wire logic align_bypass_i,
	input wire sfd_grp_t grp_mode_i,
	input wire logic [NCH-1:0][39:0] rx_data_o,
	input wire logic [NCH-1:0] rx_valid_o,
	input wire logic [NCH-1:0] rx_comma_o,
	input wire logic [NCH-1:0] rx_sync_o,
	input wire logic [NCH-1:0] rx_wclk_o,
	input wire logic [NCH/4-1:0] link_aligned_o,
	input wire logic [NCH-1:0] tx_valid_i,
	input wire logic [NCH-1:0] tx_ready_o
);
	// Every check runs on the fabric clock and sleeps in reset.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Grouping is active only for coded, non-bypassed traffic.
	sequence s_grp(m);
		!align_bypass_i && grp_mode_i == m && &dec_en_i;
	endsequence
	// A take on channel 0.
	sequence s_take;
		tx_valid_i[0] && tx_ready_o[0];
	endsequence
	property p_take_drop;
		s_take |=> !tx_ready_o[0];
	endproperty
	a_take_drop: assert property (p_take_drop) else $error("ready stayed high after a take");
	property p_ready_back;
		$fell(tx_ready_o[0]) |-> ##[1:40] tx_ready_o[0];
	endproperty
	a_ready_back: assert property (p_ready_back) else $error("transmit word never left");
	property p_pulse;
		|rx_valid_o |=> (rx_valid_o & $past(rx_valid_o)) == '0;
	endproperty
	a_pulse: assert property (p_pulse) else $error("word pulse longer than one cycle");
	property p_comma;
		rx_valid_o[0] && dec_en_i[0] && rx_data_o[0][32] && rx_data_o[0][7:0] == SFD_K28_5 |-> rx_comma_o[0];
	endproperty
	a_comma: assert property (p_comma) else $error("comma word without comma flag");
	property p_pair;
		s_grp(SFD_GRP_PAIR) ##0 rx_valid_o[0] |-> rx_valid_o[1];
	endproperty
	a_pair: assert property (p_pair) else $error("pair members delivered apart");
	property p_quad;
		s_grp(SFD_GRP_QUAD) ##0 rx_valid_o[1] |-> &(rx_valid_o[3:0] | chan_pd_i[3:0]);
	endproperty
	a_quad: assert property (p_quad) else $error("block members delivered apart");
	property p_all;
		s_grp(SFD_GRP_ALL) ##0 rx_valid_o[1] |-> &(rx_valid_o | chan_pd_i);
	endproperty
	a_all: assert property (p_all) else $error("wide group delivered apart");
	property p_raw;
		rx_valid_o[NCH-1] && !dec_en_i[NCH-1] |-> rx_data_o[NCH-1][9:0] inside {10'h0fa, 10'h305};
	endproperty
	a_raw: assert property (p_raw) else $error("raw lane 0 is not the comma symbol");
	property p_align_rise;
		$rose(link_aligned_o[0]) |-> &(rx_sync_o[3:0] | chan_pd_i[3:0]);
	endproperty
	a_align_rise: assert property (p_align_rise) else $error("aligned without sync");
	property p_align_drop;
		$fell(rx_sync_o[0]) && !chan_pd_i[0] |-> ##[0:6] !link_aligned_o[0];
	endproperty
	a_align_drop: assert property (p_align_drop) else $error("aligned kept after sync loss");
	property p_wclk;
		align_bypass_i && $changed(rx_wclk_o[0]) |=> rx_valid_o[0];
	endproperty
	a_wclk: assert property (p_wclk) else $error("word clock edge without a word");
endmodule

// >>> test/sfd_user_model.sv
// Fabric user logic model: offers one transmit word per channel at a time.
module sfd_user_model #(
	parameter int NCH = 8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [NCH-1:0] go_i,
	input wire logic slow_i,
	input wire logic [2:0] gap_i,
	input wire logic [NCH-1:0][31:0] w_data_i,
	input wire logic [NCH-1:0][3:0] w_fneg_i,
	input wire logic [NCH-1:0] tx_ready_i,
	output logic [NCH-1:0] tx_valid_o,
	output logic [NCH-1:0][31:0] tx_data_o,
	output logic [NCH-1:0][3:0] tx_k_o,
	output logic [NCH-1:0][3:0] tx_fneg_o,
	output logic [NCH-1:0] taken_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [NCH-1:0][2:0] gap_ff; // Rest cycles left before the next offer.
	// A word is taken where valid meets ready at a rising edge.
	assign taken_o = tx_valid_o & tx_ready_i;
	// Only lane 0 carries a special character; lanes 1 to 3 are data.
	assign tx_k_o = {NCH{4'h1}};
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		// Offer and hold a word until it is taken, then rest when slow.
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				tx_valid_o[c] <= 1'b0;
				gap_ff[c] <= 3'h0;
				tx_data_o[c] <= 32'h0;
				tx_fneg_o[c] <= 4'h0;
			end else if (taken_o[c]) begin
				tx_valid_o[c] <= 1'b0;
				gap_ff[c] <= slow_i ? gap_i : 3'h0;
			end else if (gap_ff[c] != 3'h0) begin
				gap_ff[c] <= gap_ff[c] - 3'h1;
			end else if (go_i[c] && !tx_valid_o[c]) begin
				tx_valid_o[c] <= 1'b1;
				tx_data_o[c] <= w_data_i[c];
				tx_fneg_o[c] <= w_fneg_i[c];
			end
		end
	end
endmodule

// >>> test/tb_sfd_datapath.sv
// Self-checking bench: link looped back, fabric side driven by the user model.
module tb_sfd_datapath import sfd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NCH = 8;
	logic clk_i = 1'b0;
	logic lclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [NCH-1:0] chan_pd = '0, dec_en = '1, go = '0, corrupt = '0;
	logic bypass = 1'b1;
	sfd_grp_t mode = SFD_GRP_NONE;
	sfd_grp_t modes [3] = '{SFD_GRP_PAIR, SFD_GRP_QUAD, SFD_GRP_ALL};
	logic slow = 1'b0;
	logic [2:0] gap = 3'h0;
	logic [7:0] lane0 = 8'hbc;
	logic [NCH-1:0][31:0] w_data = '0, tx_data;
	logic [NCH-1:0][3:0] w_fneg = '0, tx_k, tx_fneg;
	logic [NCH-1:0][9:0] rx_sym, tx_sym;
	logic [NCH-1:0][39:0] rx_data;
	logic [NCH-1:0] rx_valid, rx_comma, rx_sync, tx_valid, tx_ready, taken;
	logic [1:0] aligned;
	logic [40:0] exp_q [NCH][$]; // Notes of {comma, word} per channel.
	int mismatches = 0;
	int tests_run = 0;
	int rounds_total = 0; // Rounds asked for by the main sequence.
	int rounds_done = 0; // Rounds started by the stimulus process.
	integer seed = 32'h9947;
	// Fabric clock, and an unrelated link clock.
	always #25 clk_i = ~clk_i;
	initial begin
		#11;
		forever #24 lclk_i = ~lclk_i;
	end
	// Loopback; a corrupted channel sees an invalid symbol.
	always_comb for (int c = 0; c < NCH; c++) rx_sym[c] = corrupt[c] ? 10'h000 : tx_sym[c];
	sfd_datapath #(.NCH(NCH)) u_sfd_datapath (.clk_i(clk_i), .reset_n_i(reset_n_i), .lclk_i(lclk_i),
		.rx_sym_i(rx_sym), .tx_sym_o(tx_sym), .chan_pd_i(chan_pd), .dec_en_i(dec_en), .align_bypass_i(bypass),
		.grp_mode_i(mode), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_comma_o(rx_comma), .rx_wclk_o(),
		.rx_sync_o(rx_sync), .link_aligned_o(aligned), .tx_data_i(tx_data), .tx_k_i(tx_k),
		.tx_fneg_i(tx_fneg), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
	sfd_user_model #(.NCH(NCH)) u_sfd_user_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .go_i(go),
		.slow_i(slow), .gap_i(gap), .w_data_i(w_data), .w_fneg_i(w_fneg), .tx_ready_i(tx_ready),
		.tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_k_o(tx_k), .tx_fneg_o(tx_fneg), .taken_o(taken));
	// Compares one value and counts it.
	task automatic check(input logic [40:0] exp, input logic [40:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t ns: expected %h, got %h", $time, exp, got);
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic final_report();
		if (mismatches == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// True once every note has been matched.
	function automatic bit drained();
		for (int c = 0; c < NCH; c++) if (exp_q[c].size() != 0) return 1'b0;
		return 1'b1;
	endfunction
	// Fresh random words each cycle; notes are made at each take on a coded channel; rounds run in lockstep.
	always @(posedge clk_i) begin
		for (int c = 0; c < NCH; c++) begin
			w_data[c] <= {24'($random(seed)), lane0};
			w_fneg[c] <= 4'($random(seed));
			if (taken[c]) begin
				go[c] <= 1'b0;
				if (dec_en[c]) exp_q[c].push_back({tx_data[c][7:0] == SFD_K28_5, 4'h0, tx_k[c], tx_data[c]});
			end
		end
		gap <= 3'($random(seed));
		if (go == '0 && rounds_done != rounds_total && tx_valid == '0) begin
			go <= ~chan_pd;
			rounds_done <= rounds_done + 1;
		end
	end
	// Each delivered coded word is matched with the oldest note of its channel; a raw word must start with a comma symbol.
	always @(posedge clk_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (rx_valid[c] === 1'b1 && dec_en[c]) begin
				if (exp_q[c].size() == 0) check({41{1'bx}}, {rx_comma[c], rx_data[c]});
				else check(exp_q[c].pop_front(), {rx_comma[c], rx_data[c]});
			end else if (rx_valid[c] === 1'b1) begin
				check(41'h1, 41'(rx_data[c][9:0] == 10'h0fa || rx_data[c][9:0] == 10'h305));
			end
		end
	end
	// Waits a bounded time until every live channel holds sync.
	task automatic wait_sync();
		int n = 0;
		while ((rx_sync | chan_pd) !== '1 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		check(41'h1, 41'(n < 400));
	endtask
	// Sends n lockstep rounds with the given lane 0 character, then drains.
	task automatic run(input int n, input logic [7:0] l0);
		int t = 0;
		lane0 <= l0;
		rounds_total <= rounds_total + n;
		@(posedge clk_i);
		while ((rounds_done != rounds_total || go != '0 || !drained()) && t < 200 * n) begin
			@(posedge clk_i);
			t++;
		end
		check(41'h1, 41'(t < 200 * n));
	endtask
	// Main sequence.
	initial begin
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		wait_sync();
		slow <= 1'b1;
		run(8, SFD_K28_5);
		dec_en[NCH-1] <= 1'b0;
		run(4, SFD_K28_5);
		dec_en[NCH-1] <= 1'b1;
		chan_pd[2] <= 1'b1;
		slow <= 1'b0;
		wait_sync();
		bypass <= 1'b0;
		foreach (modes[i]) begin
			mode <= modes[i];
			run(6, SFD_K28_3);
			if (modes[i] != SFD_GRP_PAIR) check(41'h3, 41'(aligned));
		end
		corrupt[0] <= 1'b1;
		repeat (20) @(posedge clk_i);
		check(41'h0, 41'({rx_sync[0], aligned[0]}));
		corrupt[0] <= 1'b0;
		wait_sync();
		final_report();
	end
	// Cuts a hung run short long after the tests should have ended.
	initial begin
		#2000000;
		mismatches++;
		final_report();
	end
endmodule
bind sfd_datapath sfd_datapath_checker #(.NCH(NCH)) u_sfd_datapath_checker (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.lclk_i(lclk_i), .chan_pd_i(chan_pd_i), .dec_en_i(dec_en_i), .align_bypass_i(align_bypass_i),
	.grp_mode_i(grp_mode_i), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_comma_o(rx_comma_o),
	.rx_sync_o(rx_sync_o), .rx_wclk_o(rx_wclk_o), .link_aligned_o(link_aligned_o), .tx_valid_i(tx_valid_i),
	.tx_ready_o(tx_ready_o));
